// ### hdl/i2c_hold_pkg.sv
/*
  Constants for the two-wire slave configuration block: register byte
  offsets, field positions, reset values, mode codes and hold timing.
  Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package i2c_hold_pkg;
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] OFF_CON3 = 8'h00;
  localparam logic [7:0] OFF_ADD = 8'h04;
  localparam logic [7:0] OFF_MSK = 8'h08;
  localparam logic [7:0] OFF_PAD = 8'h0C;
  localparam logic [7:0] OFF_CON1 = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_BUF = 8'h18;

  // twowire_control_three fields
  localparam int C3_ACK = 7;
  localparam int C3_PCIE = 6;
  localparam int C3_START_DETECT_IRQ_EN = 5;
  localparam int C3_BUFFER_OVERWRITE_EN = 4;
  localparam int C3_DATA_HOLD_TIME_SEL = 3;
  localparam int C3_SLAVE_COLLISION_IRQ_EN = 2;
  localparam int C3_ADDRESS_HOLD_EN = 1;
  localparam int C3_DATA_BYTE_HOLD_EN = 0;

  // serial_control_one fields
  localparam int C1_OV = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  localparam int C1_MODE = 0;

  // pad_output_disables field base (bits 11:8)
  localparam int PAD_LSB = 8;

  // reset values
  localparam logic [7:0] MSK_RESET = 8'hFF;
  localparam logic [7:0] ADD_RESET = 8'h00;

  // mode codes
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_SLV7_SP = 4'hE;
  localparam logic [3:0] MODE_SLV10_SP = 4'hF;

  // fixed upper pattern of a 10-bit high address byte
  localparam logic [4:0] TEN_HI_PAT = 5'h1E;

  // data hold after clock falling edge
  localparam int CLK_PERIOD_NS = 20;
  localparam int HOLD_SHORT_NS = 100;
  localparam int HOLD_LONG_NS = 300;
  localparam logic [3:0] HOLD_SHORT_CYC =
    4'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_LONG_CYC =
    4'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // bit counts within a byte frame
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RACK = 6'h04,
    ST_DATA = 6'h08,
    ST_TX = 6'h10,
    ST_TACK = 6'h20
  } state_e;
endpackage

// ### hdl/i2c_slave_hold_and_address_match.sv
/*
  Two-wire slave receiver/transmitter with clock holding, address match
  with per-bit ignore mask, baud reload counter for master mode, and pad
  output disables, all under an AXI4-Lite register slave.
  Assumes bus pins are already synchronous to aclk and that the pad
  resolves open-drain levels from the output enables.
*/
`timescale 1ns/100ps

module i2c_slave_hold_and_address_match (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [i2c_hold_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [i2c_hold_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // two-wire bus pins, open drain
  input wire logic twowire_clock_pin_i,
  output logic twowire_clock_pin_o,
  output logic twowire_clock_pin_oe,
  input wire logic twowire_data_pin_i,
  output logic twowire_data_pin_o,
  output logic twowire_data_pin_oe,
  // bus event pulses
  output logic start_irq,
  output logic stop_irq,
  output logic collision_irq,
  // master baud clock
  output logic baud_clk,
  // spi pad outputs, bits {port2 dout, port2 sclk, port1 dout, port1 sclk}
  input wire logic [3:0] spi_core_out,
  output logic [3:0] spi_pad_out,
  output logic [3:0] spi_pad_oe
);
  import i2c_hold_pkg::*;

  typedef struct packed {
    state_e state;
    state_e nxt;
    logic [3:0] bcnt;
    logic [7:0] shift;
    logic [7:0] txsh;
    logic is_addr;
    logic ten_hi_ok;
    logic ten_lo_ok;
    logic nack;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] hold_cnt;
    logic sda_next;
    logic sda_oe;
    logic scl_oe;
    logic [6:0] con3;
    logic ack_flag;
    logic [7:0] add;
    logic [7:0] msk;
    logic [3:0] pad_dis;
    logic [3:0] mode;
    logic en;
    logic clock_release;
    logic ov;
    logic bf;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic [7:0] brg_cnt;
    logic brg_clk;
    logic start_irq;
    logic stop_irq;
    logic coll_irq;
    logic [3:0] pad_o;
    logic [3:0] pad_oe;
    logic aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s s_q;
  state_s s_d;

  // unmasked bits of the received byte must all equal the address
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] add,
                                    input logic [7:0] ign);
    addr_hit = &(~(rx ^ add) | ign);
  endfunction

  // next-state logic for bus slave, protocol engine, baud counter and pads
  always_comb begin
    logic slave;
    logic ten;
    logic sp_mode;
    logic hold_act;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic drv_set;
    logic drv_val;
    logic hit;
    logic upd;
    logic [7:0] rx;
    logic [7:0] wb;
    logic [31:0] rv;
    s_d = s_q;
    slave = 1'b0;
    ten = 1'b0;
    sp_mode = 1'b0;
    hold_act = 1'b0;
    drv_set = 1'b0;
    drv_val = 1'b0;
    hit = 1'b0;
    upd = 1'b0;
    rx = s_q.shift;
    wb = s_q.wdata[7:0];
    rv = 32'h0000_0000;
    // bus conditions from the previous pin levels
    rise = twowire_clock_pin_i && !s_q.scl_prev;
    fall = !twowire_clock_pin_i && s_q.scl_prev;
    start_c = twowire_clock_pin_i && s_q.scl_prev && s_q.sda_prev && !twowire_data_pin_i;
    stop_c = twowire_clock_pin_i && s_q.scl_prev && !s_q.sda_prev && twowire_data_pin_i;
    s_d.start_irq = 1'b0;
    s_d.stop_irq = 1'b0;
    s_d.coll_irq = 1'b0;

    // register writes: address and data taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.awaddr)
        OFF_CON3: if (s_q.wstrb[0]) s_d.con3 = wb[6:0];
        OFF_ADD: if (s_q.wstrb[0]) s_d.add = wb;
        OFF_MSK: if (s_q.wstrb[0]) s_d.msk = wb;
        OFF_PAD: if (s_q.wstrb[1]) s_d.pad_dis = s_q.wdata[PAD_LSB+:4];
        OFF_CON1: begin
          if (s_q.wstrb[0]) begin
            s_d.ov = wb[C1_OV];
            s_d.en = wb[C1_EN];
            s_d.clock_release = wb[C1_CKP];
            s_d.mode = wb[C1_MODE+:4];
          end
        end
        OFF_STAT: ;
        OFF_BUF: if (s_q.wstrb[0]) s_d.txbuf = wb;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    // register reads, upper bits zero
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (araddr)
        OFF_CON3: rv[7:0] = {s_q.ack_flag, s_q.con3};
        OFF_ADD: rv[7:0] = s_q.add;
        OFF_MSK: rv[7:0] = s_q.msk;
        OFF_PAD: rv[PAD_LSB+:4] = s_q.pad_dis;
        OFF_CON1: rv[7:0] = {1'b0, s_q.ov, s_q.en, s_q.clock_release, s_q.mode};
        OFF_STAT: rv[0] = s_q.bf;
        OFF_BUF: begin
          rv[7:0] = s_q.rxbuf;
          s_d.bf = 1'b0; // reading drains the holding buffer
        end
        default: s_d.rresp = RESP_SLVERR;
      endcase
      s_d.rdata = rv;
    end

    // mode decode
    slave = s_q.en && (s_q.mode == MODE_SLV7 || s_q.mode == MODE_SLV10 ||
                       s_q.mode == MODE_SLV7_SP || s_q.mode == MODE_SLV10_SP);
    ten = (s_q.mode == MODE_SLV10 || s_q.mode == MODE_SLV10_SP);
    sp_mode = (s_q.mode == MODE_SLV7_SP || s_q.mode == MODE_SLV10_SP);
    hold_act = (s_q.con3[C3_ADDRESS_HOLD_EN] || s_q.con3[C3_DATA_BYTE_HOLD_EN]) && !sp_mode;

    // pin history for next cycle's edge and condition detection
    s_d.scl_prev = twowire_clock_pin_i;
    s_d.sda_prev = twowire_data_pin_i;

    // delayed data change keeps the hold time after each falling edge
    if (s_q.hold_cnt != 4'h0) begin
      s_d.hold_cnt = s_q.hold_cnt - 4'h1;
      if (s_q.hold_cnt == 4'h1) begin
        s_d.sda_oe = s_q.sda_next;
      end
    end

    if (!slave) begin
      s_d.state = ST_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.hold_cnt = 4'h0;
      s_d.ack_flag = 1'b0;
    end else if (stop_c) begin
      s_d.state = ST_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.hold_cnt = 4'h0;
      s_d.ten_hi_ok = 1'b0;
      s_d.ten_lo_ok = 1'b0;
      s_d.stop_irq = s_q.con3[C3_PCIE] || sp_mode;
    end else if (start_c) begin
      s_d.state = ST_ADDR;
      s_d.is_addr = 1'b1;
      s_d.bcnt = 4'h0;
      s_d.sda_oe = 1'b0;
      s_d.hold_cnt = 4'h0;
      s_d.start_irq = s_q.con3[C3_START_DETECT_IRQ_EN] || sp_mode;
    end else begin
      case (s_q.state)
        ST_ADDR, ST_DATA: begin
          if (rise && s_q.bcnt < BITS_BYTE) begin
            s_d.shift = {s_q.shift[6:0], twowire_data_pin_i};
            s_d.bcnt = s_q.bcnt + 4'h1;
          end else if (fall && s_q.bcnt == BITS_BYTE) begin
            s_d.nxt = ST_DATA;
            if (s_q.state == ST_DATA) begin
              hit = 1'b1;
            end else if (!ten) begin
              hit = addr_hit(rx, s_q.add, s_q.msk | 8'h01);
              s_d.nxt = rx[0] ? ST_TX : ST_DATA;
            end else if (rx[7:3] == TEN_HI_PAT) begin
              hit = addr_hit(rx, s_q.add, s_q.msk | 8'hF9);
              s_d.ten_hi_ok = hit;
              s_d.nxt = (s_q.ten_lo_ok && rx[0]) ? ST_TX : ST_ADDR;
            end else begin
              hit = s_q.ten_hi_ok && addr_hit(rx, s_q.add, s_q.msk);
              s_d.ten_lo_ok = hit;
            end
            if (hit) begin
              upd = !s_q.bf && (s_q.con3[C3_BUFFER_OVERWRITE_EN] || !s_q.ov);
              if (s_q.bf) begin
                s_d.ov = 1'b1;
              end
              if (upd) begin
                s_d.rxbuf = rx;
                s_d.bf = 1'b1;
              end else begin
                s_d.nxt = ST_IDLE;
              end
              if (hold_act) begin
                s_d.ack_flag = 1'b1;
              end
              if ((s_q.is_addr && s_q.con3[C3_ADDRESS_HOLD_EN]) ||
                  (!s_q.is_addr && s_q.con3[C3_DATA_BYTE_HOLD_EN])) begin
                s_d.clock_release = 1'b0;
              end
              drv_set = 1'b1;
              drv_val = upd;
              s_d.state = ST_RACK;
            end else begin
              s_d.state = ST_IDLE;
            end
          end
        end
        ST_RACK: begin
          if (rise && s_q.bcnt == BITS_BYTE) begin
            s_d.bcnt = BITS_ACK;
            s_d.ack_flag = 1'b0;
          end else if (fall && s_q.bcnt == BITS_ACK) begin
            s_d.bcnt = 4'h0;
            s_d.state = s_q.nxt;
            s_d.is_addr = (s_q.nxt == ST_ADDR);
            s_d.txsh = s_q.txbuf;
            drv_set = 1'b1;
            drv_val = (s_q.nxt == ST_TX) && !s_q.txbuf[7];
          end
        end
        ST_TX: begin
          if (rise && s_q.bcnt < BITS_BYTE) begin
            s_d.bcnt = s_q.bcnt + 4'h1;
            // released line read low means another party won
            if (!s_q.sda_oe && !twowire_data_pin_i && s_q.con3[C3_SLAVE_COLLISION_IRQ_EN]) begin
              s_d.coll_irq = 1'b1;
            end
          end else if (fall && s_q.bcnt == BITS_BYTE) begin
            drv_set = 1'b1;
            drv_val = 1'b0;
            s_d.state = ST_TACK;
            if (hold_act) begin
              s_d.ack_flag = 1'b1;
            end
          end else if (fall && s_q.bcnt != 4'h0) begin
            s_d.txsh = {s_q.txsh[6:0], 1'b0};
            drv_set = 1'b1;
            drv_val = !s_q.txsh[6];
          end
        end
        ST_TACK: begin
          if (rise && s_q.bcnt == BITS_BYTE) begin
            s_d.bcnt = BITS_ACK;
            s_d.ack_flag = 1'b0;
            s_d.nack = twowire_data_pin_i;
          end else if (fall && s_q.bcnt == BITS_ACK) begin
            s_d.bcnt = 4'h0;
            s_d.state = s_q.nack ? ST_IDLE : ST_TX;
            s_d.txsh = s_q.txbuf;
            drv_set = 1'b1;
            drv_val = !s_q.nack && !s_q.txbuf[7];
          end
        end
        ST_IDLE: ;
        default: s_d.state = ST_IDLE;
      endcase
    end

    // schedule the data line change after the selected hold time
    if (drv_set) begin
      s_d.sda_next = drv_val;
      s_d.hold_cnt = s_q.con3[C3_DATA_HOLD_TIME_SEL] ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
    end

    // clock stretched in an enabled slave mode while the release control is clear
    s_d.scl_oe = slave && !s_d.clock_release;

    // baud counter toggles every reload plus one cycles
    if (s_q.en && s_q.mode == MODE_MASTER) begin
      if (s_q.brg_cnt == 8'h00) begin
        s_d.brg_cnt = s_q.add;
        s_d.brg_clk = !s_q.brg_clk;
      end else begin
        s_d.brg_cnt = s_q.brg_cnt - 8'h01;
      end
    end else begin
      s_d.brg_cnt = 8'h00;
      s_d.brg_clk = 1'b0;
    end

    // pad drive follows the disables
    s_d.pad_o = spi_core_out;
    s_d.pad_oe = ~s_q.pad_dis;

    // one write and one read outstanding at a time
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.nxt <= ST_IDLE;
      s_q.scl_prev <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.add <= ADD_RESET;
      s_q.msk <= MSK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register, except the two pin levels tied low
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign twowire_clock_pin_o = 1'b0;
  assign twowire_clock_pin_oe = s_q.scl_oe;
  assign twowire_data_pin_o = 1'b0;
  assign twowire_data_pin_oe = s_q.sda_oe;
  assign start_irq = s_q.start_irq;
  assign stop_irq = s_q.stop_irq;
  assign collision_irq = s_q.coll_irq;
  assign baud_clk = s_q.brg_clk;
  assign spi_pad_out = s_q.pad_o;
  assign spi_pad_oe = s_q.pad_oe;
endmodule

// ### bench/i2c_master_model.sv
/*
  Two-wire bus master model: start, stop, byte send, ack slot.
  Assumes the bench resolves both open-drain lines with pull-ups and
  that the bench top offers a timeout task for a clock held too long.
*/
`timescale 1ns/100ps
module i2c_master_model (
  // clock
  input wire logic aclk,
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // pull-low enables
  output logic scl_oe,
  output logic sda_oe
);
  // half period well above the longest data hold
  localparam int HALF = 40;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // release scl, then wait out any stretch by the slave
  task automatic rise();
    int n;
    n = 0;
    scl_oe <= 1'b0;
    @(posedge aclk);
    while (scl !== 1'b1) begin
      @(posedge aclk);
      if (++n > 4000) tb_i2c_slave_hold_and_address_match.timeout();
    end
    repeat (HALF) @(posedge aclk);
  endtask
  // start or restart: sda falls while scl high
  task automatic start();
    sda_oe <= 1'b0;
    repeat (HALF) @(posedge aclk);
    rise();
    sda_oe <= 1'b1;
    repeat (HALF) @(posedge aclk);
    scl_oe <= 1'b1;
    repeat (HALF) @(posedge aclk);
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    sda_oe <= 1'b1;
    repeat (HALF) @(posedge aclk);
    rise();
    sda_oe <= 1'b0;
    repeat (HALF) @(posedge aclk);
  endtask
  // msb first; returns shortly after the eighth fall
  task automatic send8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_oe <= ~b[i];
      repeat (HALF) @(posedge aclk);
      rise();
      scl_oe <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask
  // ninth clock; a is the sampled ack level
  task automatic ack(output logic a);
    sda_oe <= 1'b0;
    repeat (HALF) @(posedge aclk);
    rise();
    a = sda;
    scl_oe <= 1'b1;
    repeat (HALF) @(posedge aclk);
  endtask
endmodule

// ### bench/i2c_hold_asserts.sv
/*
  Port-level checks of the two-wire slave block.
  Assumes one aclk domain with synchronous active-low reset.
*/
`timescale 1ns/100ps
module i2c_hold_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // two-wire pins and events
  input wire logic twowire_clock_pin_i,
  input wire logic twowire_data_pin_i,
  input wire logic twowire_clock_pin_oe,
  input wire logic start_irq,
  input wire logic stop_irq,
  // spi pad path
  input wire logic [3:0] spi_core_out,
  input wire logic [3:0] spi_pad_out
);
  import i2c_hold_pkg::*;
  logic scl_q, sda_q;
  logic [5:0] st_h, sp_h;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // recent bus conditions; pulse latency is a few cycles, so keep six
  always_ff @(posedge aclk) begin
    scl_q <= twowire_clock_pin_i;
    sda_q <= twowire_data_pin_i;
    st_h <= {st_h[4:0], scl_q & twowire_clock_pin_i & sda_q & ~twowire_data_pin_i};
    sp_h <= {sp_h[4:0], scl_q & twowire_clock_pin_i & ~sda_q & twowire_data_pin_i};
  end
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  a_start_cause: assert property (start_irq |-> |st_h)
    else $error("start pulse without start");
  a_stop_cause: assert property (stop_irq |-> |sp_h)
    else $error("stop pulse without stop");
  a_read_answer: assert property (s_ar_taken |=> rvalid)
    else $error("read not answered");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("arready during rvalid");
  a_rd_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_wr_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read not zero");
  a_upper_zero: assert property (rvalid |-> rdata[31:12] == 20'h0)
    else $error("upper bits not zero");
  a_pad_delay: assert property ($past(aresetn) |-> spi_pad_out == $past(spi_core_out))
    else $error("pad output mismatch");
  a_scl_release: assert property ($fell(twowire_clock_pin_oe) |-> bvalid || $past(bvalid))
    else $error("clock released without write");
endmodule
bind i2c_slave_hold_and_address_match i2c_hold_asserts u_chk (
  .aclk, .aresetn, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bresp,
  .bvalid, .bready, .twowire_clock_pin_i, .twowire_data_pin_i, .twowire_clock_pin_oe,
  .start_irq, .stop_irq, .spi_core_out, .spi_pad_out
);

// ### bench/tb_i2c_slave_hold_and_address_match.sv
/*
  Self-checking bench: registers, masked address match, clock and data
  hold, bus events, baud and pad paths. Needs the master model.
*/
`timescale 1ns/100ps
module tb_i2c_slave_hold_and_address_match;
  import i2c_hold_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, dscl_oe, dsda_oe, mscl_oe, msda_oe;
  logic start_irq, stop_irq, collision_irq, baud_clk, m, a, pe, ht;
  logic [7:0] awaddr, araddr, ad, mk, b, r;
  logic [7:0] fl [6], mt [6];
  logic [31:0] wdata, rdata, rdat, v;
  logic [3:0] wstrb, spi_core_out, spi_pad_out, spi_pad_oe;
  logic [1:0] bresp, rresp, rrsp;
  int fails, num_checks, cyc, tf, hd, c, n0, n1, n2, n_start, n_stop, n_coll;
  wire scl = ~(dscl_oe | mscl_oe);
  wire sda = ~(dsda_oe | msda_oe);

  i2c_slave_hold_and_address_match u_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .twowire_clock_pin_i(scl), .twowire_clock_pin_o(),
    .twowire_clock_pin_oe(dscl_oe), .twowire_data_pin_i(sda), .twowire_data_pin_o(),
    .twowire_data_pin_oe(dsda_oe), .start_irq, .stop_irq, .collision_irq,
    .baud_clk, .spi_core_out, .spi_pad_out, .spi_pad_oe
  );
  i2c_master_model u_mst (.aclk, .scl, .sda, .scl_oe(mscl_oe), .sda_oe(msda_oe));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // event counts and hold measure from the last scl fall
  always @(posedge aclk) begin
    cyc++;
    n_start += int'(start_irq === 1'b1);
    n_stop += int'(stop_irq === 1'b1);
    n_coll += int'(collision_irq === 1'b1);
  end
  always @(negedge scl) tf = cyc;
  always @(posedge dsda_oe) hd = cyc - tf;

  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic timeout();
    fails++;
    $display("[ERR] %0t wait ran out %h %h", $time, 1'b1, 1'b0);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // response ready offered with the request; each payload held until taken
  task automatic wr(input logic [7:0] ra, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= ra;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      if (++n > 99) timeout();
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ra);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= ra;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      if (++n > 99) timeout();
    end
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wlev(input logic lv);
    int n;
    n = 0;
    while (baud_clk !== lv) begin
      @(posedge aclk);
      c++;
      if (++n > 999) timeout();
    end
  endtask
  function automatic logic exp_match(logic [7:0] x, logic [7:0] y, logic [7:0] k);
    return (((x ^ y) & ~k & 8'hFE) == 8'h00);
  endfunction

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    spi_core_out = 4'h0;
    void'($urandom(91));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_MSK);
    chk(rdat, 32'hFF);
    rd(OFF_ADD);
    chk(rdat, 32'h0);
    rd(8'h1C);
    chk(rrsp, RESP_SLVERR);
    chk(rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      wr(OFF_CON3 + 8'(4 * i), v);
      rd(OFF_CON3 + 8'(4 * i));
      chk(rdat, v & (i == 0 ? 32'h7F : 32'hFF));
    end
    v = $urandom;
    wr(OFF_PAD, v);
    rd(OFF_PAD);
    chk(rdat, v & 32'hF00);
    spi_core_out <= 4'($urandom);
    repeat (3) @(posedge aclk);
    chk(spi_pad_oe, {28'h0, ~v[11:8]});
    $display("test registers done");
    // exact, bit7 off, masked bit5, random masked, mask bit0 only, random
    r = 8'($urandom);
    fl = '{8'h00, 8'h80, 8'h20, r, r, r};
    mt = '{8'h00, 8'h00, 8'h20, r, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++) begin
      ad = 8'($urandom);
      mk = mt[i];
      b = ({ad[7:1], 1'b0} ^ fl[i]) & 8'hFE;
      pe = i[0];
      ht = i[1];
      m = exp_match(b, ad, mk);
      wr(OFF_ADD, {24'h0, ad});
      wr(OFF_MSK, {24'h0, mk});
      wr(OFF_CON3, {25'h0, pe, 1'b1, 1'b0, ht, 3'b010});
      wr(OFF_CON1, 32'h36);
      n0 = n_start;
      n1 = n_stop;
      u_mst.start();
      u_mst.send8(b);
      repeat (8) @(posedge aclk);
      chk(dscl_oe, m);
      if (m) begin
        rd(OFF_CON3);
        chk(rdat[7], 1'b1);
        wr(OFF_CON1, 32'h36);
      end
      u_mst.ack(a);
      chk(a, !m);
      rd(OFF_CON3);
      chk(rdat[7], 1'b0);
      if (m) begin
        chk(hd * 20 >= (ht ? 300 : 100), 1);
        u_mst.send8(8'($urandom));
        u_mst.ack(a);
        chk(a, 1'b1);
        rd(OFF_CON1);
        chk(rdat[6], 1'b1);
        rd(OFF_BUF);
        chk(rdat, b);
        wr(OFF_CON1, 32'h36);
      end
      u_mst.stop();
      repeat (8) @(posedge aclk);
      chk(n_start - n0, 1);
      chk(n_stop - n1, pe);
      $display("test address case %0d done", i);
    end
    // 10-bit: high byte pattern, then low byte on all eight bits (bit 0 flipped once)
    for (int j = 0; j < 2; j++) begin
      ad = 8'($urandom) & 8'h7F;
      wr(OFF_ADD, {24'h0, ad});
      wr(OFF_MSK, 32'h0);
      wr(OFF_CON3, 32'h02);
      wr(OFF_CON1, 32'h37);
      u_mst.start();
      u_mst.send8({TEN_HI_PAT, ad[2:1], 1'b0});
      repeat (8) @(posedge aclk);
      chk(dscl_oe, 1'b1);
      rd(OFF_BUF);
      chk(rdat, {TEN_HI_PAT, ad[2:1], 1'b0});
      wr(OFF_CON1, 32'h37);
      u_mst.ack(a);
      u_mst.send8(ad ^ 8'(j));
      repeat (8) @(posedge aclk);
      chk(dscl_oe, j == 0);
      rd(OFF_BUF);
      wr(OFF_CON1, 32'h37);
      u_mst.ack(a);
      chk(a, j != 0);
      u_mst.stop();
      $display("test ten-bit case %0d done", j);
    end
    // slave transmit in the start/stop mode: flag inert, events forced, collisions
    ad = 8'($urandom);
    wr(OFF_ADD, {24'h0, ad});
    wr(OFF_BUF, 32'hFF);
    wr(OFF_CON3, 32'h06);
    wr(OFF_CON1, 32'h3E);
    n0 = n_start;
    n1 = n_stop;
    n2 = n_coll;
    u_mst.start();
    u_mst.send8({ad[7:1], 1'b1});
    repeat (8) @(posedge aclk);
    chk(dscl_oe, 1'b1);
    rd(OFF_CON3);
    chk(rdat[7], 1'b0);
    wr(OFF_CON1, 32'h3E);
    u_mst.ack(a);
    chk(a, 1'b0);
    u_mst.send8(8'h00);
    u_mst.ack(a);
    u_mst.stop();
    repeat (8) @(posedge aclk);
    chk(n_coll - n2, 8);
    chk(n_start - n0, 1);
    chk(n_stop - n1, 1);
    $display("test transmit done");
    r = 8'd3 + 8'($urandom % 16);
    wr(OFF_ADD, {24'h0, r});
    wr(OFF_CON1, 32'h28);
    wlev(1'b0);
    wlev(1'b1);
    c = 0;
    wlev(1'b0);
    wlev(1'b1);
    chk(c, 2 * (r + 1));
    $display("test baud done");
    print_verdict();
  end
endmodule
